// File: src/psw_regs.svh
// Register offsets, bit positions and reset values of the status word block
`ifndef PSW_REGS_SVH
`define PSW_REGS_SVH

// Register offsets on the plain register port
`define PSW_OFS_STATUS 4'h0
`define PSW_OFS_TRAP 4'h4

// Reset value of the status word and of read data
`define PSW_RST_STATUS 8'h00
`define PSW_RST_DATA 8'h00

// Field positions inside the status word
`define PSW_PRIO_HI 7
`define PSW_PRIO_LO 5
`define PSW_BIT_T 4
`define PSW_BIT_N 3
`define PSW_BIT_Z 2
`define PSW_BIT_V 1
`define PSW_BIT_C 0
`define PSW_CC_HI 3
`define PSW_CC_LO 0

// Sign bit positions of the operand mux
`define PSW_SIGN_WORD 15
`define PSW_SIGN_BYTE 7

// Zero detector spans
`define PSW_BYTE_HI 7
`define PSW_B_LEG_BUS_LO 1
`define PSW_B_LEG_BUS_WHI 14
`define PSW_B_LEG_BUS_BHI 6

// Most negative word, overflow case of negate
`define PSW_MOST_NEG 16'h8000

`endif

// File: src/psw_pkg.sv
// Types shared by the status word block
package psw_pkg;

  // Status word layout, priority down to carry
  typedef struct packed {
    logic [2:0] prio;
    logic trace;
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
  } psw_word_t;

  // Categories of the N/Z source mux, {byte, rotate}
  typedef enum logic [1:0] {
    PSW_CAT_WORD = 2'b00,
    PSW_CAT_ROTW = 2'b01,
    PSW_CAT_BYTE = 2'b10,
    PSW_CAT_ROTB = 2'b11
  } psw_cat_t;

  // Arithmetic classes seen by the carry/overflow table
  typedef enum logic [1:0] {
    PSW_OP_ADD = 2'b00,
    PSW_OP_SUB = 2'b01,
    PSW_OP_LOGIC = 2'b10,
    PSW_OP_NEG = 2'b11
  } psw_op_t;

  // Computed condition codes
  typedef struct packed {
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
  } psw_cc_t;

endpackage

// File: src/psw_status_word.sv
// Processor status word with condition code logic and trace trap flag
//
// Design decisions made here: the strobed register port and the address map.
`include "psw_regs.svh"

module psw_status_word (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // Datapath and microcode
  input wire logic [15:0] operandMux,
  input wire logic [15:0] bLegBus,
  input wire logic statusLoadN,
  input wire logic carryOnlyLoadN,
  input wire logic auxFieldSelectN,
  input wire logic byteOp,
  input wire logic rotateOp,
  input wire logic shiftOp,
  input wire psw_pkg::psw_op_t aluOpClass,
  input wire logic aluCarry,
  input wire logic aluOverflow,
  input wire logic shiftSignValue,
  input wire logic rotCarryOut,
  input wire logic rotEndZero,
  // Status outputs
  output psw_pkg::psw_word_t processorStatusWord,
  output logic traceTrapFlag
);

  // Carry/overflow lookup, {carry, ovf}
  function automatic logic [1:0] cvTable(
    input psw_pkg::psw_op_t op,
    input logic cy,
    input logic ov,
    input logic resZero,
    input logic resMostNeg,
    input logic cOld
  );
    logic [1:0] r;
    r = 2'b00;
    case (op)
      psw_pkg::PSW_OP_ADD: r = {cy, ov};
      psw_pkg::PSW_OP_SUB: r = {cy, ov};
      psw_pkg::PSW_OP_LOGIC: r = {cOld, 1'b0};
      psw_pkg::PSW_OP_NEG: r = {~resZero, resMostNeg};
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  psw_pkg::psw_word_t psw_q;
  psw_pkg::psw_word_t psw_d;
  logic traceDel_q;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;

  // Zero detectors over the result and the b-leg
  wire logic wordZero;
  wire logic byteZero;
  wire logic bLegWordZero;
  wire logic bLegByteZero;
  assign wordZero = (operandMux == 16'h0000);
  assign byteZero = (operandMux[`PSW_BYTE_HI:0] == 8'h00);
  assign bLegWordZero =
    (bLegBus[`PSW_B_LEG_BUS_WHI:`PSW_B_LEG_BUS_LO] == 14'h0000) & rotEndZero;
  assign bLegByteZero =
    (bLegBus[`PSW_B_LEG_BUS_BHI:`PSW_B_LEG_BUS_LO] == 6'h00) & rotEndZero;

  // N/Z source mux category from byte and rotate decode
  wire psw_pkg::psw_cat_t nzCat;
  assign nzCat = psw_pkg::psw_cat_t'({byteOp, rotateOp});

  // Next negative value
  wire logic negativeNext;
  assign negativeNext =
    (nzCat == psw_pkg::PSW_CAT_WORD) ? operandMux[`PSW_SIGN_WORD] :
    (nzCat == psw_pkg::PSW_CAT_BYTE) ? operandMux[`PSW_SIGN_BYTE] :
    shiftSignValue;

  // Next zero value
  wire logic zeroNext;
  assign zeroNext =
    (nzCat == psw_pkg::PSW_CAT_WORD) ? wordZero :
    (nzCat == psw_pkg::PSW_CAT_BYTE) ? byteZero :
    (nzCat == psw_pkg::PSW_CAT_ROTW) ? bLegWordZero :
    bLegByteZero;

  // Table outputs and subtract gating
  wire logic [1:0] cvRaw;
  wire logic tableCarry;
  wire logic isSub;
  assign cvRaw = cvTable(aluOpClass, aluCarry, aluOverflow, wordZero,
    (operandMux == `PSW_MOST_NEG), psw_q.carry);
  assign isSub = (aluOpClass == psw_pkg::PSW_OP_SUB);
  assign tableCarry = cvRaw[1] ^ isSub;

  // Shift and rotate override of C and V
  wire logic carryNext;
  wire logic overflowNext;
  assign carryNext = shiftOp ? rotCarryOut : tableCarry;
  assign overflowNext =
    shiftOp ? (negativeNext ^ carryNext) : cvRaw[0];

  // Computed flags
  wire psw_pkg::psw_cc_t ccComputed;
  assign ccComputed = '{neg: negativeNext, zero: zeroNext,
    ovf: overflowNext, carry: carryNext};

  // Flag input selector, high takes operand mux
  wire psw_pkg::psw_cc_t ccSelected;
  assign ccSelected = auxFieldSelectN ?
    psw_pkg::psw_cc_t'(operandMux[`PSW_CC_HI:`PSW_CC_LO]) :
    ccComputed;

  // Register port decode
  wire logic selStatus;
  wire logic selTrap;
  wire logic swWrite;
  wire logic statusLoad;
  wire logic carryLoad;
  assign selStatus = (regAddr == `PSW_OFS_STATUS);
  assign selTrap = (regAddr == `PSW_OFS_TRAP);
  assign swWrite = regWrStb & selStatus;
  assign statusLoad = ~statusLoadN;
  assign carryLoad = ~carryOnlyLoadN;

  // Next status word; hardware loads win over software writes
  always_comb begin
    psw_d = psw_q;
    if (statusLoad) begin
      psw_d.prio = operandMux[`PSW_PRIO_HI:`PSW_PRIO_LO];
      psw_d.trace = operandMux[`PSW_BIT_T];
      psw_d.neg = ccSelected.neg;
      psw_d.zero = ccSelected.zero;
      psw_d.ovf = ccSelected.ovf;
      psw_d.carry = ccSelected.carry;
    end else if (carryLoad) begin
      psw_d.carry = ccSelected.carry;
    end else if (swWrite) begin
      psw_d = psw_pkg::psw_word_t'(regWrData);
    end
  end

  // Read data mux, zero on unmapped offsets
  always_comb begin
    rdData_d = `PSW_RST_DATA;
    if (selStatus) begin
      rdData_d = psw_q;
    end else if (selTrap) begin
      rdData_d = {7'h00, traceDel_q};
    end
  end

  // Status word flops on the free-running clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      psw_q <= psw_pkg::psw_word_t'(`PSW_RST_STATUS);
    end else begin
      psw_q <= psw_d;
    end
  end

  // Delayed trace copy serves as trap request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      traceDel_q <= 1'b0;
    end else begin
      traceDel_q <= psw_q.trace;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdData_q <= `PSW_RST_DATA;
    end else if (regRdStb) begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;
  assign processorStatusWord = psw_q;
  assign traceTrapFlag = traceDel_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence traceRise;
    !psw_q.trace ##1 psw_q.trace;
  endsequence

  // Trace bit falling, trap request must drop one cycle later
  sequence traceFall;
    psw_q.trace ##1 !psw_q.trace;
  endsequence

  sequence execLoad;
    !statusLoadN && !auxFieldSelectN && !shiftOp;
  endsequence

  // Full load with the computed flags, any instruction kind
  sequence ccLoad;
    !statusLoadN && !auxFieldSelectN;
  endsequence

  // Software write to the status word with no hardware load
  sequence swStatusWrite;
    regWrStb && (regAddr == `PSW_OFS_STATUS) && statusLoadN && carryOnlyLoadN;
  endsequence

  // Software read of the status word
  sequence statusRead;
    regRdStb && (regAddr == `PSW_OFS_STATUS);
  endsequence

  // Word loads, carry-only loads, hold, software writes and trace trap delay
  chk_vector_load: assert property (
    (!statusLoadN && auxFieldSelectN) |=> (psw_q == $past(operandMux[`PSW_PRIO_HI:`PSW_BIT_C])))
    else $error("status word not loaded from operand mux");

  chk_prio_trace_src: assert property (
    !statusLoadN |=> (psw_q.prio == $past(operandMux[`PSW_PRIO_HI:`PSW_PRIO_LO]))
      && (psw_q.trace == $past(operandMux[`PSW_BIT_T])))
    else $error("priority or trace not from operand mux");

  chk_hold_idle: assert property (
    (statusLoadN && carryOnlyLoadN && !regWrStb) |=> $stable(psw_q))
    else $error("status word changed with no load");

  chk_carry_only: assert property (
    (statusLoadN && !carryOnlyLoadN) |=>
      (psw_q[`PSW_PRIO_HI:`PSW_BIT_V] == $past(psw_q[`PSW_PRIO_HI:`PSW_BIT_V]))
      && (psw_q.carry == $past(auxFieldSelectN ? operandMux[`PSW_BIT_C] : carryNext)))
    else $error("carry load touched other bits");

  chk_upper_hold: assert property (
    (statusLoadN && !(regWrStb && (regAddr == `PSW_OFS_STATUS))) |=>
      $stable(psw_q[`PSW_PRIO_HI:`PSW_BIT_V]))
    else $error("upper bits changed without full load");

  chk_sw_write: assert property (
    swStatusWrite |=> (psw_q == $past(regWrData)))
    else $error("software write not taken");

  chk_sw_refused: assert property (
    (regWrStb && (regAddr != `PSW_OFS_STATUS) && statusLoadN && carryOnlyLoadN) |=>
      $stable(psw_q))
    else $error("write to read-only offset changed word");

  chk_trace_delay: assert property (
    traceRise |-> ##1 traceTrapFlag ##1 (traceTrapFlag == $past(psw_q.trace)))
    else $error("trace trap flag not delayed copy");

  chk_trap_clear: assert property (
    traceFall |-> ##1 !traceTrapFlag)
    else $error("trace trap flag did not drop");

  // Negative and zero sources
  chk_neg_word: assert property (
    (ccLoad and (!byteOp && !rotateOp)) |=>
      (psw_q.neg == $past(operandMux[`PSW_SIGN_WORD])))
    else $error("word negative flag wrong");

  chk_neg_byte: assert property (
    (ccLoad and (byteOp && !rotateOp)) |=>
      (psw_q.neg == $past(operandMux[`PSW_SIGN_BYTE])))
    else $error("byte negative flag wrong");

  chk_rot_neg: assert property (
    (ccLoad and rotateOp) |=>
      (psw_q.neg == $past(shiftSignValue)))
    else $error("rotate negative flag wrong");

  chk_zero_word: assert property (
    (ccLoad and (!byteOp && !rotateOp)) |=>
      (psw_q.zero == ($past(operandMux) == 16'h0000)))
    else $error("word zero flag wrong");

  chk_zero_byte: assert property (
    (ccLoad and (byteOp && !rotateOp)) |=>
      (psw_q.zero == ($past(operandMux[`PSW_BYTE_HI:0]) == 8'h00)))
    else $error("byte zero flag wrong");

  chk_rot_zero: assert property (
    (ccLoad and (!byteOp && rotateOp)) |=>
      (psw_q.zero == (($past(bLegBus[`PSW_B_LEG_BUS_WHI:`PSW_B_LEG_BUS_LO]) == 14'h0000) && $past(rotEndZero))))
    else $error("rotate zero flag wrong");

  chk_rotb_zero: assert property (
    (ccLoad and (byteOp && rotateOp)) |=>
      (psw_q.zero == (($past(bLegBus[`PSW_B_LEG_BUS_BHI:`PSW_B_LEG_BUS_LO]) == 6'h00) && $past(rotEndZero))))
    else $error("rotate byte zero flag wrong");

  // Carry and overflow sources
  chk_add_cv: assert property (
    (execLoad and (aluOpClass == psw_pkg::PSW_OP_ADD)) |=>
      (psw_q.carry == $past(aluCarry)) && (psw_q.ovf == $past(aluOverflow)))
    else $error("add carry or overflow wrong");

  chk_sub_carry: assert property (
    (execLoad and (aluOpClass == psw_pkg::PSW_OP_SUB)) |=>
      (psw_q.carry == !$past(aluCarry)))
    else $error("subtract carry not gated");

  chk_sub_ovf: assert property (
    (execLoad and (aluOpClass == psw_pkg::PSW_OP_SUB)) |=>
      (psw_q.ovf == $past(aluOverflow)))
    else $error("subtract overflow wrong");

  chk_logic_cv: assert property (
    (execLoad and (aluOpClass == psw_pkg::PSW_OP_LOGIC)) |=>
      (psw_q.carry == $past(psw_q.carry)) && !psw_q.ovf)
    else $error("logic op carry or overflow wrong");

  chk_neg_cv: assert property (
    (execLoad and (aluOpClass == psw_pkg::PSW_OP_NEG)) |=>
      (psw_q.carry == ($past(operandMux) != 16'h0000))
      && (psw_q.ovf == ($past(operandMux) == `PSW_MOST_NEG)))
    else $error("negate carry or overflow wrong");

  chk_shift_ovf: assert property (
    (!statusLoadN && !auxFieldSelectN && shiftOp) |=>
      (psw_q.ovf == (psw_q.neg ^ psw_q.carry))
      && (psw_q.carry == $past(rotCarryOut)))
    else $error("shift overflow not N xor C");

  // Register port reads
  chk_read_status: assert property (
    statusRead |=> (regRdData == $past(psw_q)))
    else $error("status read data wrong");

  chk_read_trap: assert property (
    (regRdStb && (regAddr == `PSW_OFS_TRAP)) |=>
      (regRdData == {7'h00, $past(traceTrapFlag)}))
    else $error("trap flag read data wrong");

  chk_read_unmapped: assert property (
    (regRdStb && (regAddr != `PSW_OFS_STATUS) && (regAddr != `PSW_OFS_TRAP)) |=>
      (regRdData == `PSW_RST_DATA))
    else $error("unmapped read not zero");

  chk_read_hold: assert property (
    !regRdStb |=> $stable(regRdData))
    else $error("read data changed without strobe");

  // Reset values, checked while reset is held
  chk_reset_word: assert property (
    disable iff (1'b0)
    !rst_n |=> (psw_q == `PSW_RST_STATUS) && !traceTrapFlag && (regRdData == `PSW_RST_DATA))
    else $error("reset values wrong");

endmodule // psw_status_word

// File: tb/psw_micro_ctl.sv
// Microprogram control model driving the status word load and select lines
module psw_micro_ctl (
  input wire logic [24:0] ctlWord,
  output logic statusLoadN,
  output logic carryOnlyLoadN,
  output logic auxFieldSelectN
);
  timeunit 1ns;
  timeprecision 1ns;

  // Low bits gate the clock enables, aux field steers the flag selector
  assign statusLoadN = ctlWord[0];
  assign carryOnlyLoadN = ctlWord[1];
  assign auxFieldSelectN = ctlWord[24];
endmodule // psw_micro_ctl

// File: tb/tb_top.sv
// Self-checking bench of the status word block
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t %s", $time, m); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [24:0] IDLE = 25'h1000003;
  localparam logic [24:0] LDV = 25'h1000002;
  localparam logic [24:0] LDC = 25'h0000002;
  localparam logic [24:0] LDCY = 25'h1000001;
  // Control {byte,rot,shift,op,cy,ov,sign,rotC,rotZ}, operand mux, b-leg, expected word
  localparam logic [49:0] ROWS [12] = '{
    {10'b000_00_11_000, 16'h8000, 16'h0000, 8'h0b}, {10'b000_00_00_000, 16'h0000, 16'h0000, 8'h04},
    {10'b000_01_00_000, 16'h0001, 16'h0000, 8'h01}, {10'b000_10_11_000, 16'h0002, 16'h0000, 8'h01},
    {10'b100_00_00_000, 16'h0080, 16'h0000, 8'h88}, {10'b100_00_00_000, 16'hff00, 16'h0000, 8'h04},
    {10'b000_11_00_000, 16'h8000, 16'h0000, 8'h0b}, {10'b000_11_11_000, 16'h0000, 16'h0000, 8'h04},
    {10'b011_00_00_101, 16'h0000, 16'h8001, 8'h0e}, {10'b111_00_00_011, 16'h0000, 16'h0080, 8'h07},
    {10'b011_00_00_011, 16'h0000, 16'h0080, 8'h03}, {10'b011_00_00_000, 16'h0000, 16'h0000, 8'h00}};

  logic clk_sys, rst_n, regWrStb, regRdStb;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rdVal;
  logic [15:0] operandMux, bLegBus;
  logic [24:0] cw;
  logic statusLoadN, carryOnlyLoadN, auxFieldSelectN;
  logic byteOp, rotateOp, shiftOp, aluCarry, aluOverflow, shiftSignValue, rotCarryOut, rotEndZero;
  psw_pkg::psw_op_t aluOpClass;
  psw_pkg::psw_word_t psw;
  logic traceTrapFlag;
  int n_errors = 0;
  int samples_checked = 0;

  psw_micro_ctl u_ctl (.ctlWord(cw), .statusLoadN(statusLoadN), .carryOnlyLoadN(carryOnlyLoadN),
    .auxFieldSelectN(auxFieldSelectN));

  psw_status_word DUT (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .operandMux(operandMux),
    .bLegBus(bLegBus), .statusLoadN(statusLoadN), .carryOnlyLoadN(carryOnlyLoadN),
    .auxFieldSelectN(auxFieldSelectN), .byteOp(byteOp), .rotateOp(rotateOp), .shiftOp(shiftOp),
    .aluOpClass(aluOpClass), .aluCarry(aluCarry), .aluOverflow(aluOverflow),
    .shiftSignValue(shiftSignValue), .rotCarryOut(rotCarryOut), .rotEndZero(rotEndZero),
    .processorStatusWord(psw), .traceTrapFlag(traceTrapFlag));

  // Free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Register write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
    #1;
  endtask

  // Register read, data sampled in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask

  // One datapath cycle with control word and operands
  task automatic dp(input logic [24:0] c, input logic [9:0] k, input logic [15:0] m, input logic [15:0] b);
    @(posedge clk_sys);
    cw <= c;
    {byteOp, rotateOp, shiftOp} <= k[9:7];
    aluOpClass <= psw_pkg::psw_op_t'(k[6:5]);
    {aluCarry, aluOverflow, shiftSignValue, rotCarryOut, rotEndZero} <= k[4:0];
    operandMux <= m;
    bLegBus <= b;
    @(posedge clk_sys);
    cw <= IDLE;
    #1;
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {regWrStb, regRdStb, regAddr, regWrData} = '0;
    cw = IDLE;
    dp_init: begin
      {byteOp, rotateOp, shiftOp, aluCarry, aluOverflow, shiftSignValue, rotCarryOut, rotEndZero} = '0;
      aluOpClass = psw_pkg::PSW_OP_ADD;
      operandMux = '0;
      bLegBus = '0;
    end
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK(psw, 8'h00, "reset word")
    `CHK(traceTrapFlag, 1'b0, "reset trap")
    dp(LDV, 10'h0, 16'h00b5, 16'h0);
    `CHK(psw, 8'hb5, "vector load")
    @(posedge clk_sys);
    #1;
    `CHK(traceTrapFlag, 1'b1, "trap flag")
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(psw, 8'hb5, "hold")
    dp(LDCY, 10'h0, 16'h00f0, 16'h0);
    `CHK(psw, 8'hb4, "carry only")
    for (int i = 0; i < 12; i++) begin
      dp(LDC, ROWS[i][49:40], ROWS[i][39:24], ROWS[i][23:8]);
      `CHK(psw, ROWS[i][7:0], "computed flags")
    end
    wr(4'h0, 8'h5a);
    `CHK(psw, 8'h5a, "sw write")
    rd(4'h0);
    `CHK(rdVal, 8'h5a, "sw read")
    rd(4'h4);
    `CHK(rdVal, 8'h01, "trap readback")
    rd(4'h2);
    `CHK(rdVal, 8'h00, "unmapped read")
    wr(4'h4, 8'hff);
    `CHK(psw, 8'h5a, "ro write")
    // Hardware load in the same cycle as a software write
    @(posedge clk_sys);
    cw <= LDV;
    operandMux <= 16'h0011;
    wr(4'h0, 8'hc3);
    cw <= IDLE;
    `CHK(psw, 8'h11, "load wins")
    print_verdict();
  end
endmodule // tb_top
